// >>> src/jifa_top.sv
// test-port front end with indirect flash register access
module jifa_top
  import jifa_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic [7:0] flash_access_mode_control_out,
  output logic [1:0] flash_sel_out,
  output logic flash_req_out,
  output logic flash_write_out,
  output logic [PAY_W-1:0] write_payload_out,
  input wire logic flash_done_in,
  input wire logic [PAY_W-1:0] read_payload_in
);
  logic [2:0] tck_s1_ff, tck_s2_ff;
  logic tck_d_ff;
  logic [3:0] in_sync;
  logic tck_rise, tck_fall;
  jifa_tap_e state;
  jifa_phase_s ph;
  logic [IR_W-1:0] ir_sh_ff, ir_ff;
  logic [31:0] dr_sh_ff;
  logic [IND_W-1:0] ind_sh_ff;
  logic [5:0] ind_cnt_ff;
  logic busy_ff;
  logic [PAY_W-1:0] read_payload_ff;
  logic [7:0] fctl_ff;
  logic [2:0] op_cnt_ff;
  logic flash_req_ff, flash_write_ff;
  logic [1:0] flash_sel_ff;
  logic [PAY_W-1:0] wpay_ff;
  logic tdo_ff, tdo_oe_ff;
  logic ind_sel, busy_seen_low_ff;

  function automatic logic is_ind(input logic [IR_W-1:0] code);
    is_ind = (code == IR_FCTL) || (code == IR_FDAT) || (code == IR_FADR) || (code == IR_FSCL);
  endfunction

  function automatic logic is_access(input logic [1:0] op);
    is_access = (op == OP_READ) || (op == OP_WRITE);
  endfunction

  function automatic logic is_write(input logic [1:0] op);
    is_write = (op == OP_WRITE);
  endfunction

  // two-stage pin synchronisers
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tck_s1_ff <= 3'h0;
      tck_s2_ff <= 3'h0;
      tck_d_ff <= 1'b0;
    end else begin
      tck_s1_ff <= {tck_in, tms_in, tdi_in};
      tck_s2_ff <= tck_s1_ff;
      tck_d_ff <= tck_s2_ff[2];
    end
  end
  logic [1:0] trst_s_ff;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trst_s_ff <= 2'h0;
    end else begin
      trst_s_ff <= {trst_s_ff[0], trst_n_in};
    end
  end
  assign in_sync = {tck_s2_ff, trst_s_ff[1]};
  assign tck_rise = in_sync[3] & ~tck_d_ff;
  assign tck_fall = ~in_sync[3] & tck_d_ff;
  logic tap_rst;
  // test-port reset also returns the controller to its reset state
  assign tap_rst = rst_in | ~trst_s_ff[1];

  jifa_tap_fsm u_fsm (
    .ref_clk_in(ref_clk_in),
    .rst_in(tap_rst),
    .tck_rise_in(tck_rise & in_sync[0]),
    .tms_in(in_sync[2]),
    .state_out(state)
  );

  assign ph.capture = tck_rise && (state == TAP_CAP_DR || state == TAP_CAP_IR);
  assign ph.shift = tck_rise && (state == TAP_SH_DR || state == TAP_SH_IR);
  assign ph.update = tck_rise && (state == TAP_UPD_DR || state == TAP_UPD_IR);
  assign ph.ir_sel = (state == TAP_CAP_IR || state == TAP_SH_IR || state == TAP_UPD_IR);
  assign ind_sel = is_ind(ir_ff);

  // instruction register; test-port reset loads the identification code
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ir_sh_ff <= IR_IDCODE;
      ir_ff <= IR_IDCODE;
    end else if (!in_sync[0] || state == TAP_RESET) begin
      ir_ff <= IR_IDCODE;
    end else if (ph.ir_sel && ph.capture) begin
      ir_sh_ff <= IR_CAPTURE;
    end else if (ph.ir_sel && ph.shift) begin
      ir_sh_ff <= {in_sync[1], ir_sh_ff[IR_W-1:1]};
    end else if (ph.ir_sel && ph.update) begin
      ir_ff <= ir_sh_ff;
    end
  end

  // plain data path: identification and bypass
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dr_sh_ff <= 32'h0000_0000;
    end else if (!ph.ir_sel && ph.capture) begin
      dr_sh_ff <= (ir_ff == IR_IDCODE) ? ID_VALUE : 32'h0000_0000;
    end else if (!ph.ir_sel && ph.shift) begin
      dr_sh_ff <= (ir_ff == IR_IDCODE) ? {in_sync[1], dr_sh_ff[31:1]} : {31'h0, in_sync[1]};
    end
  end

  // indirect shift register: capture loads zero, result and busy
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ind_sh_ff <= 20'h0_0000;
      ind_cnt_ff <= 6'h00;
    end else if (!ph.ir_sel && ph.capture && ind_sel) begin
      ind_sh_ff <= {1'b0, read_payload_ff, busy_ff};
      ind_cnt_ff <= 6'h00;
    end else if (!ph.ir_sel && ph.shift && ind_sel) begin
      ind_sh_ff <= {in_sync[1], ind_sh_ff[IND_W-1:1]};
      ind_cnt_ff <= (ind_cnt_ff == 6'h3f) ? ind_cnt_ff : ind_cnt_ff + 6'h01;
    end
  end

  // bits enter at the top, so whatever the length the last two shifted sit
  // in the opcode field and the payload stands left-justified below them
  logic [1:0] cmd_op;
  logic [PAY_W-1:0] cmd_pay;
  always_comb begin
    cmd_op = ind_sh_ff[OP_HI:OP_LO];
    cmd_pay = ind_sh_ff[PAY_W-1:0];
  end
  logic start;
  // poll (0x) never updates; read/write only when busy was seen low
  assign start = !ph.ir_sel && ph.update && ind_sel && ind_cnt_ff >= 6'h02
               && is_access(cmd_op) && !busy_ff && busy_seen_low_ff;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_seen_low_ff <= 1'b1;
    end else if (!ph.ir_sel && ph.capture && ind_sel) begin
      busy_seen_low_ff <= !busy_ff;
    end else if (start) begin
      busy_seen_low_ff <= 1'b0;
    end
  end

  // operation engine
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_ff <= 1'b0;
      flash_req_ff <= 1'b0;
      flash_write_ff <= 1'b0;
      flash_sel_ff <= 2'h0;
      wpay_ff <= 18'h0_0000;
      op_cnt_ff <= 3'h0;
    end else if (start) begin
      busy_ff <= 1'b1;
      flash_req_ff <= 1'b1;
      flash_write_ff <= is_write(cmd_op);
      flash_sel_ff <= 2'(ir_ff - IR_FCTL);
      wpay_ff <= cmd_pay;
      op_cnt_ff <= 3'(OP_CYCLES);
    end else begin
      flash_req_ff <= 1'b0;
      if (busy_ff && (flash_sel_ff == 2'h0 ? op_cnt_ff == 3'h1 : flash_done_in)) begin
        busy_ff <= 1'b0;
      end
      if (op_cnt_ff != 3'h0) begin
        op_cnt_ff <= op_cnt_ff - 3'h1;
      end
    end
  end

  // mode control register held locally; other targets answer via done
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fctl_ff <= FCTL_RST;
      read_payload_ff <= 18'h0_0000;
    end else if (busy_ff && flash_sel_ff == 2'h0 && op_cnt_ff == 3'h1) begin
      if (flash_write_ff) begin
        fctl_ff <= wpay_ff[PAY_W-1 -: 8];
      end else begin
        read_payload_ff <= {10'h000, fctl_ff};
      end
    end else if (busy_ff && flash_sel_ff != 2'h0 && flash_done_in && !flash_write_ff) begin
      read_payload_ff <= read_payload_in;
    end
  end

  // output changes on falling test clock
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (!in_sync[0]) begin
      tdo_oe_ff <= 1'b0;
      tdo_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_ff <= (state == TAP_SH_DR || state == TAP_SH_IR);
      tdo_ff <= ph.ir_sel ? ir_sh_ff[0] : (ind_sel ? ind_sh_ff[0] : dr_sh_ff[0]);
    end
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe_out = tdo_oe_ff;
  assign flash_access_mode_control_out = fctl_ff;
  assign flash_sel_out = flash_sel_ff;
  assign flash_req_out = flash_req_ff;
  assign flash_write_out = flash_write_ff;
  assign write_payload_out = wpay_ff;
endmodule

// >>> src/jifa_pkg.sv
// constants and types for the test-port indirect flash access block
package jifa_pkg;
  localparam int IR_W = 16;
  localparam int IND_W = 20;
  localparam int PAY_W = 18;
  localparam int OP_HI = 19;
  localparam int OP_LO = 18;
  localparam logic [IR_W-1:0] IR_EXTEST = 16'h0000;
  localparam logic [IR_W-1:0] IR_SAMPLE = 16'h0002;
  localparam logic [IR_W-1:0] IR_IDCODE = 16'h0004;
  localparam logic [IR_W-1:0] IR_BYPASS = 16'hffff;
  localparam logic [IR_W-1:0] IR_FCTL = 16'h0082;
  localparam logic [IR_W-1:0] IR_FDAT = 16'h0083;
  localparam logic [IR_W-1:0] IR_FADR = 16'h0084;
  localparam logic [IR_W-1:0] IR_FSCL = 16'h0085;
  localparam logic [IR_W-1:0] IR_CAPTURE = 16'h0001;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h3;
  // identity values are arbitrary
  localparam logic [3:0] ID_REV = 4'h6;
  localparam logic [15:0] ID_PART = 16'h0abc;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic [31:0] ID_VALUE = {ID_REV, ID_PART, ID_MAKER, 1'b1};
  localparam logic [7:0] FCTL_RST = 8'h00;
  localparam int OP_CYCLES = 4;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } jifa_tap_e;
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic ir_sel;
  } jifa_phase_s;
endpackage

// >>> src/jifa_tap_fsm.sv
// test-port controller state machine
module jifa_tap_fsm
  import jifa_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic tck_rise_in,
  input wire logic tms_in,
  output jifa_tap_e state_out
);
  jifa_tap_e state_ff;
  jifa_tap_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TAP_RESET: nxt_state = tms_in ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nxt_state = tms_in ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_state = tms_in ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt_state = tms_in ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: nxt_state = tms_in ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nxt_state = tms_in ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: nxt_state = tms_in ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: nxt_state = tms_in ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: nxt_state = tms_in ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt_state = tms_in ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: nxt_state = tms_in ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: nxt_state = tms_in ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nxt_state = tms_in ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: nxt_state = tms_in ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: nxt_state = tms_in ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: nxt_state = tms_in ? TAP_SEL_DR : TAP_IDLE;
      default: nxt_state = TAP_RESET;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= TAP_RESET;
    end else if (tck_rise_in) begin
      state_ff <= nxt_state;
    end
  end

  assign state_out = state_ff;
endmodule

// >>> verification/jifa_checker.sv
// port assertions for the test-port indirect flash access block
module jifa_checker
  import jifa_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic trst_n_in,
  input wire logic tdo_oe_out,
  input wire logic [7:0] flash_access_mode_control_out,
  input wire logic [1:0] flash_sel_out,
  input wire logic flash_req_out,
  input wire logic flash_write_out,
  input wire logic [PAY_W-1:0] write_payload_out,
  input wire logic flash_done_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_req_pulse; flash_req_out |=> !flash_req_out; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request wider than one cycle");
  property p_ctl_busy; flash_req_out && flash_sel_out == 2'h0 |=> !flash_req_out [*4]; endproperty
  a_ctl_busy: assert property (p_ctl_busy) else $error("request while control busy");
  property p_wait_done;
    flash_req_out && flash_sel_out != 2'h0 |=> !flash_req_out until flash_done_in;
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("request before done");
  property p_hold_target;
    flash_req_out && flash_sel_out != 2'h0 |=>
      ($stable(flash_sel_out) && $stable(flash_write_out)) until flash_done_in;
  endproperty
  a_hold_target: assert property (p_hold_target) else $error("target moved in flight");
  property p_mode_src;
    !$stable(flash_access_mode_control_out) |-> $past(flash_sel_out) == 2'h0 && $past(flash_write_out);
  endproperty
  a_mode_src: assert property (p_mode_src) else $error("mode changed without write");
  property p_mode_write;
    flash_req_out && flash_write_out && flash_sel_out == 2'h0 |->
      ##[1:6] flash_access_mode_control_out == write_payload_out[17:10];
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not loaded");
  property p_trst_idle; !trst_n_in [*8] |-> !tdo_oe_out; endproperty
  a_trst_idle: assert property (p_trst_idle) else $error("driving during port reset");
  property p_req_no_shift; flash_req_out |-> !tdo_oe_out; endproperty
  a_req_no_shift: assert property (p_req_no_shift) else $error("request during shift");
endmodule
bind jifa_top jifa_checker chk (.ref_clk_in, .rst_in, .trst_n_in, .tdo_oe_out,
  .flash_access_mode_control_out, .flash_sel_out, .flash_req_out, .flash_write_out,
  .write_payload_out, .flash_done_in);

// >>> verification/jifa_flash_model.sv
// flash side responder with adjustable answer delay
module jifa_flash_model
  import jifa_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [1:0] sel_in,
  input wire logic [PAY_W-1:0] payload_in,
  input wire logic [7:0] delay_in,
  output logic done_out,
  output logic [PAY_W-1:0] rdata_out,
  output logic [7:0] reqs_out
);
  logic [7:0] mem [4];
  logic [7:0] cnt;
  logic busy;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      done_out <= 1'b0;
      rdata_out <= '0;
      reqs_out <= 8'h00;
    end else begin
      done_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in) begin
        busy <= 1'b1;
        cnt <= delay_in;
        reqs_out <= reqs_out + 8'h01;
        if (write_in) mem[sel_in] <= payload_in[17:10];
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        done_out <= 1'b1;
        rdata_out <= {10'h000, mem[sel_in]};
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// >>> verification/testbench.sv
// self-checking bench for the test-port indirect flash access block
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench
  import jifa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_n = 1'b1;
  logic tdo, oe, req, wr, done, b0;
  logic [7:0] mode, w, n0, nreq, dly = 8'h00;
  logic [1:0] sel;
  logic [PAY_W-1:0] pay, rdat;
  logic [31:0] seed, q;
  int error_cnt = 0, samples_checked = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  jifa_top dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(oe),
    .flash_access_mode_control_out(mode), .flash_sel_out(sel), .flash_req_out(req),
    .flash_write_out(wr), .write_payload_out(pay), .flash_done_in(done),
    .read_payload_in(rdat));
  jifa_flash_model model (.clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req),
    .write_in(wr), .sel_in(sel), .payload_in(pay), .delay_in(dly), .done_out(done),
    .rdata_out(rdat), .reqs_out(nreq));
  task automatic tclk(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    tck <= 1'b1;
    @(negedge ref_clk_in) o = tdo;
    repeat (4) @(posedge ref_clk_in);
  endtask
  task automatic scan(input logic ir, input logic [31:0] v, input int n, output logic [31:0] r);
    logic o;
    r = '0;
    tclk(1'b1, 1'b0, o);
    if (ir) tclk(1'b1, 1'b0, o);
    tclk(1'b0, 1'b0, o);
    tclk(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tclk(i == n - 1, v[i], o);
      r[i] = o;
    end
    tclk(1'b1, 1'b0, o);
    tclk(1'b0, 1'b0, o);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [7:0] b, output logic bz);
    scan(1'b0, op[0] ? {22'h0, op, b} : {30'h0, op}, op[0] ? 10 : 2, q);
    bz = q[0];
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 40; k++) begin
      scan(1'b0, 32'h0, 1, q);
      if (q[0] === 1'b0) break;
    end
    `CHK("busy", 1'b0, q[0])
  endtask
  function automatic logic [19:0] exp_frame(input logic [7:0] v);
    return {1'b0, 10'h000, v, 1'b0};
  endfunction
  task automatic rw(input logic [7:0] v);
    cmd(OP_READ, 8'h00, b0);
    wait_idle();
    scan(1'b0, 32'h0004_0000, 20, q);
    `CHK("read", exp_frame(v), q[19:0])
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2_000_000;
    error_cnt++;
    summarize();
  end
  initial begin
    seed = 32'hd97a6633;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    tclk(1'b0, 1'b0, b0);
    scan(1'b0, 32'h0, 32, q);
    `CHK("id", ID_VALUE, q)
    $display("test identification done");
    for (int t = 0; t < 4; t++) begin
      w = 8'($random(seed));
      dly <= 8'($random(seed)) & 8'h1f;
      scan(1'b1, {16'h0, IR_FCTL + 16'(t)}, 16, q);
      cmd(OP_WRITE, w, b0);
      wait_idle();
      if (t == 0) `CHK("mode", w, mode)
      rw(w);
      if (t == 0) `CHK("mode after poll", w, mode)
      $display("test target %0d done", t);
    end
    dly <= 8'd40;
    n0 = nreq;
    cmd(OP_WRITE, 8'h5a, b0);
    for (int i = 1; i < 20; i++) begin
      cmd(OP_WRITE, 8'h5a + 8'(i), b0);
      w = 8'h5a + 8'(i);
      if (b0 === 1'b0) break;
    end
    wait_idle();
    `CHK("request count", n0 + 8'd2, nreq)
    rw(w);
    $display("test busy overlap done");
    @(posedge ref_clk_in) trst_n <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    trst_n <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    tclk(1'b0, 1'b0, b0);
    scan(1'b0, 32'h0, 32, q);
    `CHK("id after port reset", ID_VALUE, q)
    $display("test port reset done");
    summarize();
  end
endmodule
